// ---- bench/arss_cmp_model.sv ----
// Purpose: Comparator and analog inputs in front of the sequencer.
// Assumes: Channel levels are given in output codes, ten bits each.
// Notes:   Purely combinational; the design synchronises the decision.
`timescale 1ns/1ps
`default_nettype none
module arss_cmp_model (
   // Selected channel and trial code.
   input  wire logic [2:0]  chan_in,
   input  wire logic [9:0]  code_in,
   // Levels of the eight channels.
   input  wire logic [79:0] vin_in,
   // Decision.
   output logic             cmp_out
);
   logic [9:0] level;
   // The trial level sits half a step below its code, so an equal level compares high.
   always_comb begin
      level = vin_in[chan_in*10 +: 10];
      cmp_out = (level >= code_in);
   end
endmodule : arss_cmp_model
`default_nettype wire

// ---- bench/arss_top_bench.sv ----
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Zero-wait APB slave; results are rebuilt from channel levels.
// Notes:   Untouched channels are checked only after a full sweep set them.
`timescale 1ns/1ps
`default_nettype none
module arss_top_bench;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, cmp, sample, irq, er, res, sh;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, ctrl;
   logic [2:0]  chan, ch;
   logic [9:0]  code;
   logic [79:0] vin_bus;
   logic [31:0] expr [8];
   int          error_cnt, compares, cycles, seed, per, g;
   arss_top u_arss_top (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
      .pslverr_out(pslverr), .cmp_in(cmp), .chan_out(chan), .dac_code_out(code), .sample_out(sample),
      .irq_out(irq));
   arss_cmp_model u_arss_cmp_model (.chan_in(chan), .code_in(code), .vin_in(vin_bus), .cmp_out(cmp));
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // A hang is cut short well past the longest run.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : rdc
   function automatic logic [31:0] ev(input int i);
      logic [9:0] v;
      v = vin_bus[i*10 +: 10];
      return res ? {22'h0, v} : {24'h0, v[9:2]};
   endfunction : ev
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] d, input logic [2:0] c,
                                       input logic [1:0] gr);
      return {18'h0, sh, res, 2'h0, gr, 1'b0, c, d, m};
   endfunction : ctl
   task automatic new_vin;
      for (int i = 0; i < 8; i++) vin_bus[i*10 +: 10] <= 10'($random(seed));
      res = 1'($random(seed));
      sh = 1'($random(seed));
   endtask : new_vin
   task automatic chk_all;
      for (int i = 0; i < 8; i++) rdc("result", 8'(8'h20 + 4 * i), expr[i]);
   endtask : chk_all
   // Counts starts of sampling; per ends as the gap between the last two.
   task automatic wait_conv(input int n);
      int k, c;
      logic prev;
      k = 0;
      c = 0;
      prev = sample;
      while (k < n) begin
         @(posedge clk);
         c++;
         if (sample === 1'b1 && prev === 1'b0) begin
            k++;
            per = c;
            c = 0;
         end
         prev = sample;
      end
   endtask : wait_conv
   initial begin
      {psel, penable, pwrite, paddr, pwdata, vin_bus} = '0;
      {error_cnt, compares, cycles} = '0;
      seed = 64356;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdc("ctrl", arss_pkg::ADDR_CTRL, arss_pkg::CTRL_RESET);
      rdc("start", arss_pkg::ADDR_START, 32'h0);
      rdc("status", arss_pkg::ADDR_STATUS, 32'h0);
      rdc("mask", arss_pkg::ADDR_MASK, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      apb(1'b1, 8'h22, 32'h1);
      chk("misaligned err", 32'h1, {31'h0, er});
      $display("test registers done");
      // Single sweep over every group size, corner levels on the outer channels.
      for (g = 3; g >= 0; g--) begin
         new_vin();
         vin_bus[9:0] <= 10'h000;
         vin_bus[79:70] <= 10'h3ff;
         apb(1'b1, arss_pkg::ADDR_MASK, {31'h0, 1'(g)});
         apb(1'b1, arss_pkg::ADDR_CTRL, ctl(2'h1, 2'(g), 3'h0, 2'(g)));
         apb(1'b1, arss_pkg::ADDR_START, 32'h1);
         repeat (3) @(posedge clk);
         chk("first channel", 32'h0, {29'h0, chan});
         rd = 32'h0;
         for (int t = 0; t < 3000 && rd[0] !== 1'b1; t++) apb(1'b0, arss_pkg::ADDR_STATUS, 32'h0);
         chk("done", 32'h1, rd);
         rdc("start after sweep", arss_pkg::ADDR_START, 32'h0);
         chk("irq", {31'h0, 1'(g)}, {31'h0, irq});
         for (int i = 0; i <= 2 * g + 1; i++) expr[i] = ev(i);
         chk_all();
         apb(1'b1, arss_pkg::ADDR_STATUS, 32'h1);
         rdc("status cleared", arss_pkg::ADDR_STATUS, 32'h0);
         repeat (2) @(posedge clk);
         chk("irq cleared", 32'h0, {31'h0, irq});
         $display("test single sweep group %0d done", g);
      end
      // Repeat mode on divider codes zero to two, with a level change while running.
      for (g = 0; g < 3; g++) begin
         new_vin();
         ch = 3'($random(seed));
         ctrl = ctl(2'h0, 2'(g), ch, 2'h0);
         apb(1'b1, arss_pkg::ADDR_CTRL, ctrl);
         apb(1'b1, arss_pkg::ADDR_START, 32'h1);
         repeat (3) @(posedge clk);
         chk("repeat channel", {29'h0, ch}, {29'h0, chan});
         wait_conv(3);
         chk("period in range", 32'h1, 32'((per >= (12 - sh) * (32 >> g)) && (per <= (14 - sh) * (32 >> g) + 4)));
         rdc("start running", arss_pkg::ADDR_START, 32'h1);
         rdc("no request", arss_pkg::ADDR_STATUS, 32'h0);
         expr[ch] = ev(ch);
         chk_all();
         vin_bus[ch*10 +: 10] <= ~vin_bus[ch*10 +: 10];
         wait_conv(3);
         expr[ch] = ev(ch);
         rdc("repeat update", 8'(8'h20 + 4 * ch), expr[ch]);
         apb(1'b1, arss_pkg::ADDR_CTRL, ~ctrl);
         rdc("ctrl locked", arss_pkg::ADDR_CTRL, ctrl);
         apb(1'b1, arss_pkg::ADDR_START, 32'h0);
         rdc("stopped", arss_pkg::ADDR_START, 32'h0);
         chk_all();
         $display("test repeat divider %0d done", g);
      end
      // Repeat sweep 0 and the spare mode code, two full sweeps each.
      for (int m = 2; m < 4; m++) begin
         new_vin();
         g = 2'($random(seed));
         apb(1'b1, arss_pkg::ADDR_CTRL, ctl(2'(m), 2'h2, 3'h0, 2'(g)));
         apb(1'b1, arss_pkg::ADDR_START, 32'h1);
         repeat (3) @(posedge clk);
         chk("sweep start channel", 32'h0, {29'h0, chan});
         wait_conv(4 * g + 5);
         rdc("never done", arss_pkg::ADDR_STATUS, 32'h0);
         rdc("still running", arss_pkg::ADDR_START, 32'h1);
         apb(1'b1, arss_pkg::ADDR_START, 32'h0);
         for (int i = 0; i <= 2 * g + 1; i++) expr[i] = ev(i);
         chk_all();
         chk("irq idle", 32'h0, {31'h0, irq});
         $display("test repeat sweep mode %0d done", m);
      end
      close_out();
   end
endmodule : arss_top_bench
`default_nettype wire

// ---- bench/arss_top_sva.sv ----
// Purpose: Port-level assertions for the converter sequencer.
// Assumes: Bound to arss_top; the APB master keeps the protocol.
// Notes:   The mask bit is mirrored from APB writes, as status is not visible.
`timescale 1ns/1ps
`default_nettype none
module arss_sva (
   // Clock and reset.
   input wire logic        ref_clk_in,
   input wire logic        rst_n_in,
   // APB.
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic        pready_out,
   input wire logic [31:0] prdata_out,
   input wire logic        pslverr_out,
   // Converter side.
   input wire logic [2:0]  chan_out,
   input wire logic [9:0]  dac_code_out,
   input wire logic        sample_out,
   input wire logic        irq_out
);
   logic mask_mirror;
   logic next_mask_mirror;
   logic in_map;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Track the mask word so that a stray interrupt can be caught.
   always_comb begin
      next_mask_mirror = mask_mirror;
      if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == arss_pkg::ADDR_MASK) begin
         next_mask_mirror = pwdata_in[arss_pkg::DONE_BIT];
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mask_mirror <= 1'b0;
      end else begin
         mask_mirror <= next_mask_mirror;
      end
   end
   // Control words sit at 0x00 to 0x0c, results at 0x20 to 0x3c.
   assign in_map = (paddr_in[1:0] == 2'h0) && (paddr_in[7:4] == 4'h0 || paddr_in[7:5] == 3'h1);
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_access;
      psel_in && penable_in && pready_out;
   endsequence
   property p_ready;
      s_setup |=> s_access;
   endproperty
   a_ready: assert property (p_ready) else $error("pready missing after setup");
   property p_ready_once;
      pready_out |=> !pready_out;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready held too long");
   property p_err_map;
      pready_out |-> pslverr_out == !in_map;
   endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
   property p_err_rdata;
      pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
   endproperty
   a_err_rdata: assert property (p_err_rdata) else $error("refused read not zero");
   property p_irq_mask;
      irq_out |-> $past(mask_mirror);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
   property p_sample_mid;
      sample_out |-> dac_code_out == arss_pkg::SAR_MIDPT;
   endproperty
   a_sample_mid: assert property (p_sample_mid) else $error("trial code not midpoint");
   property p_sample_len;
      $rose(sample_out) |-> ##[1:130] !sample_out;
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sampling too long");
   property p_conv_gap;
      $fell(sample_out) |-> !sample_out [*8];
   endproperty
   a_conv_gap: assert property (p_conv_gap) else $error("bit phase too short");
   property p_chan_hold;
      sample_out && $past(sample_out) |-> $stable(chan_out);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel moved while sampling");
endmodule : arss_sva
bind arss_top arss_sva u_arss_sva (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out), .chan_out(chan_out),
   .dac_code_out(dac_code_out), .sample_out(sample_out), .irq_out(irq_out));
`default_nettype wire

// ---- hw/arss_sar.sv ----
// Purpose: Successive-approximation engine: sample, then resolve ten bits.
// Assumes: Comparator level is already synchronised; one tick per comparison.
// Notes:   Restarts by itself while enabled; dropping the enable aborts.
`timescale 1ns/1ps
`default_nettype none
module arss_sar (
   // Clock and reset.
   input  wire logic                       clk_in,
   input  wire logic                       rst_n_in,
   // Control from the sequencer.
   input  wire logic                       en_in,
   input  wire logic                       tick_in,
   input  wire logic                       hold_in,
   input  wire logic                       cmp_in,
   // Trial code, sampling phase and completion.
   output logic [arss_pkg::SAR_W-1:0]      code_out,
   output logic                            sample_out,
   output logic                            done_out
);
   typedef enum logic [2:0] {
      SAR_IDLE   = 3'b001,
      SAR_SAMPLE = 3'b010,
      SAR_BITS   = 3'b100
   } arss_sar_st_t;
   arss_sar_st_t               st, next_st;
   logic [3:0]                 cnt, next_cnt;
   logic [arss_pkg::SAR_W-1:0] next_code;
   logic                       next_sample, next_done;
   // Next state; a compare uses the code driven since the previous tick.
   always_comb begin
      next_st     = st;
      next_cnt    = cnt;
      next_code   = code_out;
      next_sample = sample_out;
      next_done   = 1'b0;
      case (st)
         SAR_IDLE: begin
            if (en_in) begin
               next_st     = SAR_SAMPLE;
               next_sample = 1'b1;
               next_code   = arss_pkg::SAR_MIDPT;
               next_cnt    = hold_in ? arss_pkg::SAMPLE_TICKS_SH
                                     : arss_pkg::SAMPLE_TICKS_PLAIN;
            end
         end
         SAR_SAMPLE: begin
            if (tick_in) begin
               if (cnt == 4'h1) begin
                  next_st     = SAR_BITS;
                  next_sample = 1'b0;
                  next_cnt    = arss_pkg::SAR_TOP;
               end else begin
                  next_cnt = cnt - 4'h1;
               end
            end
         end
         SAR_BITS: begin
            if (tick_in) begin
               next_code[cnt] = cmp_in;
               if (cnt == 4'h0) begin
                  next_st   = SAR_IDLE;
                  next_done = 1'b1;
               end else begin
                  next_code[cnt - 4'h1] = 1'b1;
                  next_cnt              = cnt - 4'h1;
               end
            end
         end
         default: begin
            next_st = SAR_IDLE;
         end
      endcase
      // Abort wins over the state, sample and done updates so a stop never leaves a stale pulse.
      if (!en_in) begin
         next_st     = SAR_IDLE;
         next_sample = 1'b0;
         next_done   = 1'b0;
      end
   end

   // Registers.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st         <= SAR_IDLE;
         cnt        <= 4'h0;
         code_out   <= '0;
         sample_out <= 1'b0;
         done_out   <= 1'b0;
      end else begin
         st         <= next_st;
         cnt        <= next_cnt;
         code_out   <= next_code;
         sample_out <= next_sample;
         done_out   <= next_done;
      end
   end
endmodule : arss_sar
`default_nettype wire

// ---- hw/arss_top.sv ----
// Purpose: Conversion sequencer for repeat, single sweep and repeat sweep 0.
// Assumes: APB slave on the reference clock; comparator input is asynchronous.
// Notes:   Control fields should only change while the start flag is clear.
`timescale 1ns/1ps
`default_nettype none
// Function
// - In repeat mode a write of one to the start flag begins converting the selected channel.
// - In repeat mode each finished conversion lands in that channel's result and leaves the request bit alone.
// - Repeat mode restarts conversions on the same channel until software clears the start flag.
// - The conversion clock is the source clock divided by four, by two, or undivided.
// - Repeat mode converts exactly one of channels zero to seven, picked by the channel field.
// - Both sweep modes begin at channel zero and write its result to result zero.
// - The sweep group is channels zero to one, three, five or seven.
// - Single sweep converts each group channel in turn, storing each result as it finishes.
// - After the last channel of a single sweep the request bit sets, the start flag clears, and it halts.
// - Repeat sweep 0 loops over the group, storing every result, and never sets the request bit.
// - Repeat sweep 0 runs while the start flag is one and stops when software writes zero.
// - Each conversion resolves ten bits from bit nine down, one comparison per bit.
// - In eight-bit resolution the result is the upper eight bits of the approximation.
module arss_top (
   // Clock and reset.
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   // APB slave.
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic [31:0]      prdata_out,
   output logic             pslverr_out,
   // Analog front end.
   input  wire logic        cmp_in,
   output logic [2:0]       chan_out,
   output logic [9:0]       dac_code_out,
   output logic             sample_out,
   // Interrupt.
   output logic             irq_out
);
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_CONV = 2'b10
   } arss_seq_t;

   logic [1:0]           rst_pipe;
   logic                 rst_n;
   logic [2:0]           cmp_sync;
   logic                 cmp_level, next_cmp_level;
   logic [4:0]           tick_cnt, next_tick_cnt;
   logic                 tick, next_tick;
   arss_seq_t            seq, next_seq;
   arss_pkg::arss_mode_t mode, next_mode;
   logic [1:0]           div_sel, next_div_sel;
   logic [2:0]           chan_sel, next_chan_sel;
   logic [1:0]           grp_sel, next_grp_sel;
   logic                 res10, next_res10;
   logic                 sh_en, next_sh_en;
   logic                 start, next_start;
   logic                 done_st, next_done_st;
   logic                 done_mask, next_done_mask;
   logic [2:0]           next_chan;
   logic [9:0]           result [arss_pkg::N_CHAN];
   logic [9:0]           next_result [arss_pkg::N_CHAN];
   logic                 next_pready, next_pslverr, next_irq;
   logic [31:0]          next_prdata, rd_word;
   logic                 mapped, wr;
   logic                 conv_done;
   logic [9:0]           conv_code;

   // Reset release through two flops; assertion stays asynchronous.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Comparator level counts only once the second and third stages agree.
   always_comb begin
      next_cmp_level = (cmp_sync[1] == cmp_sync[2]) ? cmp_sync[2] : cmp_level;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cmp_sync  <= 3'b000;
         cmp_level <= 1'b0;
      end else begin
         cmp_sync  <= {cmp_sync[1:0], cmp_in};
         cmp_level <= next_cmp_level;
      end
   end

   // Conversion clock tick; even the fastest rate gives the comparator filter time.
   always_comb begin
      logic [4:0] lim;
      lim = arss_pkg::TICK_LIM_DIV1;
      if (div_sel == arss_pkg::DIV_BY4) begin
         lim = arss_pkg::TICK_LIM_DIV4;
      end else if (div_sel == arss_pkg::DIV_BY2) begin
         lim = arss_pkg::TICK_LIM_DIV2;
      end
      next_tick     = (tick_cnt >= lim);
      next_tick_cnt = next_tick ? 5'h00 : tick_cnt + 5'h01;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 5'h00;
         tick     <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick     <= next_tick;
      end
   end

   // Approximation engine; it runs whenever the sequencer is converting.
   arss_sar u_sar (
      .clk_in     (ref_clk_in),
      .rst_n_in   (rst_n),
      .en_in      (seq == SEQ_CONV),
      .tick_in    (tick),
      .hold_in    (sh_en),
      .cmp_in     (cmp_level),
      .code_out   (conv_code),
      .sample_out (sample_out),
      .done_out   (conv_done)
   );
   assign dac_code_out = conv_code;

   // Address decode and read mux.
   always_comb begin
      mapped  = 1'b1;
      rd_word = 32'h0000_0000;
      if (paddr_in[1:0] != 2'h0) begin
         mapped = 1'b0;
      end else if (paddr_in[7:5] == arss_pkg::RESULT_PAGE) begin
         rd_word[9:0] = result[paddr_in[4:2]];
      end else begin
         case (paddr_in)
            arss_pkg::ADDR_CTRL: begin
               rd_word[arss_pkg::CTRL_MODE_LSB +: 2] = mode;
               rd_word[arss_pkg::CTRL_DIV_LSB +: 2]  = div_sel;
               rd_word[arss_pkg::CTRL_CHAN_LSB +: 3] = chan_sel;
               rd_word[arss_pkg::CTRL_GRP_LSB +: 2]  = grp_sel;
               rd_word[arss_pkg::CTRL_RES_BIT]       = res10;
               rd_word[arss_pkg::CTRL_SH_BIT]        = sh_en;
            end
            arss_pkg::ADDR_START:  rd_word[arss_pkg::START_BIT] = start;
            arss_pkg::ADDR_STATUS: rd_word[arss_pkg::DONE_BIT] = done_st;
            arss_pkg::ADDR_MASK:   rd_word[arss_pkg::DONE_BIT] = done_mask;
            default:               mapped = 1'b0;
         endcase
      end
      wr = psel_in & penable_in & pwrite_in & pready_out & mapped;
   end

   // APB answer is prepared in the setup cycle, so every access has no wait.
   always_comb begin
      next_pready  = psel_in & ~penable_in;
      next_prdata  = (psel_in & ~penable_in & ~pwrite_in) ? rd_word : prdata_out;
      next_pslverr = psel_in & ~penable_in & ~mapped;
      next_irq     = done_st & done_mask;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
         irq_out     <= 1'b0;
      end else begin
         pready_out  <= next_pready;
         prdata_out  <= next_prdata;
         pslverr_out <= next_pslverr;
         irq_out     <= next_irq;
      end
   end

   // Sequencer and software-visible control state.
   always_comb begin
      logic [9:0] fmt;
      logic       hw_stop, irq_set;
      fmt            = res10 ? conv_code : {2'b00, conv_code[9:2]};
      hw_stop        = 1'b0;
      irq_set        = 1'b0;
      next_seq       = seq;
      next_chan      = chan_out;
      next_result    = result;
      next_mode      = mode;
      next_div_sel   = div_sel;
      next_chan_sel  = chan_sel;
      next_grp_sel   = grp_sel;
      next_res10     = res10;
      next_sh_en     = sh_en;
      next_done_mask = done_mask;
      case (seq)
         SEQ_IDLE: begin
            if (start) begin
               next_seq  = SEQ_CONV;
               next_chan = (mode == arss_pkg::MODE_REPEAT) ? chan_sel : 3'h0;
            end
         end
         SEQ_CONV: begin
            if (!start) begin
               next_seq = SEQ_IDLE;
            end else if (conv_done) begin
               next_result[chan_out] = fmt;
               if (mode == arss_pkg::MODE_REPEAT) begin
                  next_chan = chan_out;
               end else if (chan_out == {grp_sel, 1'b1}) begin
                  next_chan = 3'h0;
                  if (mode == arss_pkg::MODE_SINGLE) begin
                     irq_set  = 1'b1;
                     hw_stop  = 1'b1;
                     next_seq = SEQ_IDLE;
                  end
               end else begin
                  next_chan = chan_out + 3'h1;
               end
            end
         end
         default: begin
            next_seq = SEQ_IDLE;
         end
      endcase
      // Start flag: hardware clear, then a software write in the same cycle wins.
      next_start = hw_stop ? 1'b0 : start;
      if (wr && paddr_in == arss_pkg::ADDR_START) begin
         next_start = pwdata_in[arss_pkg::START_BIT];
      end
      // Control writes are dropped while running so a sweep never changes shape.
      if (wr && paddr_in == arss_pkg::ADDR_CTRL && !start) begin
         next_mode     = arss_pkg::arss_mode_t'(pwdata_in[arss_pkg::CTRL_MODE_LSB +: 2]);
         next_div_sel  = pwdata_in[arss_pkg::CTRL_DIV_LSB +: 2];
         next_chan_sel = pwdata_in[arss_pkg::CTRL_CHAN_LSB +: 3];
         next_grp_sel  = pwdata_in[arss_pkg::CTRL_GRP_LSB +: 2];
         next_res10    = pwdata_in[arss_pkg::CTRL_RES_BIT];
         next_sh_en    = pwdata_in[arss_pkg::CTRL_SH_BIT];
      end
      if (wr && paddr_in == arss_pkg::ADDR_MASK) begin
         next_done_mask = pwdata_in[arss_pkg::DONE_BIT];
      end
      // Sticky request: a set in the clearing cycle is kept.
      next_done_st = done_st;
      if (wr && paddr_in == arss_pkg::ADDR_STATUS && pwdata_in[arss_pkg::DONE_BIT]) begin
         next_done_st = 1'b0;
      end
      if (irq_set) begin
         next_done_st = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         seq       <= SEQ_IDLE;
         chan_out  <= 3'h0;
         mode      <= arss_pkg::arss_mode_t'(arss_pkg::CTRL_RESET[arss_pkg::CTRL_MODE_LSB +: 2]);
         div_sel   <= arss_pkg::CTRL_RESET[arss_pkg::CTRL_DIV_LSB +: 2];
         chan_sel  <= arss_pkg::CTRL_RESET[arss_pkg::CTRL_CHAN_LSB +: 3];
         grp_sel   <= arss_pkg::CTRL_RESET[arss_pkg::CTRL_GRP_LSB +: 2];
         res10     <= arss_pkg::CTRL_RESET[arss_pkg::CTRL_RES_BIT];
         sh_en     <= arss_pkg::CTRL_RESET[arss_pkg::CTRL_SH_BIT];
         start     <= 1'b0;
         done_st   <= 1'b0;
         done_mask <= 1'b0;
         for (int i = 0; i < arss_pkg::N_CHAN; i++) begin
            result[i] <= 10'h000;
         end
      end else begin
         seq       <= next_seq;
         chan_out  <= next_chan;
         mode      <= next_mode;
         div_sel   <= next_div_sel;
         chan_sel  <= next_chan_sel;
         grp_sel   <= next_grp_sel;
         res10     <= next_res10;
         sh_en     <= next_sh_en;
         start     <= next_start;
         done_st   <= next_done_st;
         done_mask <= next_done_mask;
         result    <= next_result;
      end
   end
endmodule : arss_top
`default_nettype wire

// ---- shared/arss_pkg.sv ----
// Purpose: Constants, register map and encodings of the converter sequencer.
// Assumes: APB with 32-bit data, byte addresses, one aligned word per register.
// Notes:   Shared by the sequencer top and its successive-approximation engine.
`default_nettype none
package arss_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_START  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0c;
   // Result registers occupy 8'h20 to 8'h3c, one word per channel.
   localparam logic [2:0] RESULT_PAGE = 3'h1;
   // Control register field positions.
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_DIV_LSB  = 2;
   localparam int unsigned CTRL_CHAN_LSB = 4;
   localparam int unsigned CTRL_GRP_LSB  = 8;
   localparam int unsigned CTRL_RES_BIT  = 12;
   localparam int unsigned CTRL_SH_BIT   = 13;
   localparam int unsigned START_BIT     = 0;
   localparam int unsigned DONE_BIT      = 0;
   // Operating modes; the spare code behaves as repeat sweep 0.
   typedef enum logic [1:0] {
      MODE_REPEAT  = 2'h0,
      MODE_SINGLE  = 2'h1,
      MODE_RSWEEP0 = 2'h2,
      MODE_SPARE   = 2'h3
   } arss_mode_t;
   // Conversion clock divider codes; the two spare codes run undivided.
   localparam logic [1:0] DIV_BY4 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   // Reference clocks per converter source clock period, and tick limits.
   localparam int unsigned FAD_PRESCALE = 8;
   localparam logic [4:0] TICK_LIM_DIV4 = 5'(FAD_PRESCALE * 4 - 1);
   localparam logic [4:0] TICK_LIM_DIV2 = 5'(FAD_PRESCALE * 2 - 1);
   localparam logic [4:0] TICK_LIM_DIV1 = 5'(FAD_PRESCALE - 1);
   // Sampling length in conversion clock ticks, without and with hold.
   localparam logic [3:0] SAMPLE_TICKS_PLAIN = 4'h3;
   localparam logic [3:0] SAMPLE_TICKS_SH    = 4'h2;
   // Approximation register width, top bit and trial start code.
   localparam int unsigned SAR_W     = 10;
   localparam logic [3:0] SAR_TOP    = 4'h9;
   localparam logic [9:0] SAR_MIDPT  = 10'h200;
   localparam int unsigned N_CHAN    = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage : arss_pkg
`default_nettype wire
